// ===== ids_pkg.sv
package ids_pkg;

  // ==========================================================
  // Logical devices and register banks
  localparam int NUM_DEV = 5;
  localparam logic [2:0] DEV_FDC = 3'h0;
  localparam logic [2:0] DEV_PP = 3'h1;
  localparam logic [2:0] DEV_UART1 = 3'h2;
  localparam logic [2:0] DEV_UART2 = 3'h3;
  localparam logic [2:0] DEV_SCI = 3'h4;
  localparam logic [2:0] BANK_GLOBAL = 3'h5;

  // ==========================================================
  // Per-device register offsets inside a bank
  localparam logic [7:0] OFF_ACTIVATE = 8'h30;
  localparam logic [7:0] OFF_BASE = 8'h60;
  localparam logic [7:0] OFF_IRQ_SEL = 8'h70;
  localparam logic [7:0] OFF_DMA_SEL = 8'h74;
  localparam logic [7:0] OFF_GATE = 8'h80;

  // ==========================================================
  // Global bank offsets
  localparam logic [7:0] OFF_TASK_BASE = 8'h00;
  localparam logic [7:0] OFF_MISC_BASE = 8'h04;
  localparam logic [7:0] OFF_TWO_WIRE_BASE = 8'h08;
  localparam logic [7:0] OFF_PM_BASE = 8'h0C;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h10;

  // ==========================================================
  // Reset values
  localparam logic [3:0] IRQ_SEL_RESET = 4'h0;
  localparam logic [2:0] DMA_SEL_RESET = 3'h4;

  // ==========================================================
  // Device gate word fields
  localparam int GATE_FDC_POWER_DOWN = 0;
  localparam int GATE_FDC_DMA = 3;
  localparam int GATE_PP_MODE = 0;
  localparam int GATE_PP_SERVICE_MASK = 2;
  localparam int GATE_PP_ECP_DMA = 3;
  localparam int GATE_PP_IRQ = 4;
  localparam int GATE_PP_ECR_MODE = 5;
  localparam int GATE_UART_IER = 0;
  localparam int GATE_UART_AUX = 10;
  localparam logic [1:0] PP_MODE_SPP = 2'h0;
  localparam logic [1:0] PP_MODE_ECP = 2'h2;
  localparam logic [2:0] ECR_FIFO = 3'h2;
  localparam logic [2:0] ECR_ECP = 3'h3;
  localparam logic [2:0] ECR_TEST = 3'h6;

  // ==========================================================
  // Interrupt select codes
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [3:0] IRQ_RESERVED = 4'h2;
  localparam logic [3:0] IRQ_SCI_ONLY = 4'hD;

  // ==========================================================
  // Address decode
  localparam logic [11:0] BASE_MIN = 12'h100;
  localparam logic [11:0] ALIGN8_MASK = 12'h007;
  localparam logic [11:0] ALIGN4_MASK = 12'h003;
  localparam logic [3:0] PM_LAST_CTRL = 4'h5;
  localparam logic [3:0] PM_TIMER_FIRST = 4'h8;
  localparam logic [3:0] PM_TIMER_LAST = 4'hB;
  localparam logic [2:0] SCI_RESERVED = 3'h5;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ids_apb_req_type;

  typedef struct packed {
    logic [NUM_DEV-1:0][3:0] irqSel;
    logic [NUM_DEV-1:0][2:0] dmaSel;
    logic [NUM_DEV-1:0][11:0] devBase;
    logic [NUM_DEV-1:0] devActive;
    logic [NUM_DEV-1:0][15:0] devGate;
    logic [11:0] taskBase;
    logic [11:0] miscBase;
    logic [11:0] twoWireBase;
    logic [11:0] pmBase;
    logic [11:0] addrMeta;
    logic [11:0] addrSync;
    logic [3:0] dackMeta_n;
    logic [3:0] dackSync_n;
    logic [15:0] irqLine;
    logic [15:0] irqOe_n;
    logic [3:0] dmaLine;
    logic [3:0] dmaOe_n;
    logic [NUM_DEV-1:0] devDack;
    logic taskSelect_n;
    logic auxSelect_n;
    logic twoWireHit;
    logic [1:0] twoWireOffset;
    logic pmHit;
    logic [3:0] pmOffset;
    logic sciHit;
    logic [2:0] sciOffset;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ids_state_type;

endpackage

// ===== ids_route.sv
module ids_route #(
  parameter bit IS_SCI = 1'b0
) (
  // Selection
  input wire logic [3:0] irqSel,
  input wire logic [2:0] dmaSel,
  // Gates
  input wire logic devOn,
  input wire logic irqEnable,
  input wire logic dmaEnable,
  input wire logic irqActiveLow,
  // Requests
  input wire logic irqReq,
  input wire logic dma_request_line,
  // Routed lines
  output logic [15:0] irqDrive,
  output logic [15:0] irqValue,
  output logic [3:0] dmaDrive,
  output logic [3:0] dmaValue
);

  logic irqCodeOk;
  logic irqOn;
  logic dmaOn;

  // ==========================================================
  // Interrupt line
  assign irqCodeOk = irqSel != ids_pkg::IRQ_NONE && irqSel != ids_pkg::IRQ_RESERVED
                     && (IS_SCI || irqSel != ids_pkg::IRQ_SCI_ONLY); // see RULE1 see RULE2
  assign irqOn = devOn && irqEnable && irqCodeOk; // see RULE4 see RULE13
  assign irqDrive = irqOn ? (16'h0001 << irqSel) : 16'h0000;
  // Edge polarity flips only for the parallel port's enhanced modes
  assign irqValue = irqDrive & {16{irqReq ^ irqActiveLow}}; // see RULE3

  // ==========================================================
  // DMA channel
  assign dmaOn = devOn && dmaEnable && !dmaSel[2]; // see RULE10 see RULE11
  assign dmaDrive = dmaOn ? (4'h1 << dmaSel[1:0]) : 4'h0;
  assign dmaValue = dmaDrive & {4{dma_request_line}};

endmodule

// ===== ids_steering.sv
// Contract
// RULE1: Low select nibble picks interrupt line number
// RULE2: Line thirteen only for system control interrupt
// RULE3: Interrupts are high edges except enhanced parallel
// RULE4: Drive line only when selected and enabled
// RULE5: Floppy gate off or powered down: tri-state
// RULE6: Parallel irq needs gate; ECP needs mask clear
// RULE7: UART irq needs an enable bit and aux
// RULE8: UART aux output low tri-states its interrupt
// RULE9: Unselected interrupt lines stay high impedance
// RULE10: DMA codes zero-three pick channel, else none
// RULE11: DMA active needs valid code and gate
// RULE12: Unselected DMA request lines stay high impedance
// RULE13: Device register disables also drop irq/ack
// RULE14: SPP/EPP parallel gate clear tri-states interrupt
// RULE15: ECP DMA follows gate; irq per mode
// RULE16: Drive and address decode need only configuration
// RULE17: Base decode uses address bits eleven-zero
// RULE18: Task select eight bytes, aux select one
// RULE19: Two-wire bus decodes four registers, aligned
// RULE20: Power events decode status/enable/control and timer
// RULE21: System control block decodes eight-byte layout
// RULE22: Out-of-range base ignores accesses, disables device
// RULE23: Unused select bits read zero, ignore writes
//
// The APB interface to the registers was chosen for this implementation.
module ids_steering (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Register bus
  input wire ids_pkg::ids_apb_req_type apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Requests from the logical devices
  input wire logic [ids_pkg::NUM_DEV-1:0] devIrqReq,
  input wire logic [ids_pkg::NUM_DEV-1:0] devDmaReq,
  output logic [ids_pkg::NUM_DEV-1:0] devDack,
  // ISA pins
  input wire logic [11:0] isaAddr,
  input wire logic [3:0] dmaAck_n,
  output logic [15:0] irqLine,
  output logic [15:0] irqOe_n,
  output logic [3:0] dmaLine,
  output logic [3:0] dmaOe_n,
  // Address decode
  output logic driveTaskSelect_n,
  output logic driveAuxSelect_n,
  output logic twoWireHit,
  output logic [1:0] twoWireOffset,
  output logic pmHit,
  output logic [3:0] pmOffset,
  output logic sciHit,
  output logic [2:0] sciOffset
);

  ids_pkg::ids_state_type st;
  ids_pkg::ids_state_type next_st;
  logic [ids_pkg::NUM_DEV-1:0] baseOk;
  logic [ids_pkg::NUM_DEV-1:0] devOn;
  logic [ids_pkg::NUM_DEV-1:0] irqEn;
  logic [ids_pkg::NUM_DEV-1:0] floppy_dma_gate;
  logic [ids_pkg::NUM_DEV-1:0] activeLow;
  logic [ids_pkg::NUM_DEV-1:0][15:0] routeIrqDrive;
  logic [ids_pkg::NUM_DEV-1:0][15:0] routeIrqValue;
  logic [ids_pkg::NUM_DEV-1:0][3:0] routeDmaDrive;
  logic [ids_pkg::NUM_DEV-1:0][3:0] routeDmaValue;
  logic [15:0] anyIrqDrive;
  logic [15:0] anyIrqValue;
  logic [3:0] anyDmaDrive;
  logic [3:0] anyDmaValue;
  logic [2:0] bank;
  logic [7:0] regOff;
  logic [32:0] rdWord;
  logic ppEcp;
  logic ecrOn;
  logic [3:0] pmOff;

  // ==========================================================
  // Base validity and device gates
  function automatic logic baseValid(input logic [11:0] b, input logic [11:0] lo, input logic [11:0] mask);
    baseValid = b >= lo && (b & mask) == 12'h000;
  endfunction

  // Only A11:A0 are ever compared, so upper address bits are not stored
  assign baseOk[ids_pkg::DEV_FDC] = baseValid(st.devBase[ids_pkg::DEV_FDC], ids_pkg::BASE_MIN,
                                              ids_pkg::ALIGN8_MASK); // see RULE22
  assign baseOk[ids_pkg::DEV_PP] = baseValid(st.devBase[ids_pkg::DEV_PP], ids_pkg::BASE_MIN,
                                             ids_pkg::ALIGN4_MASK); // see RULE22
  assign baseOk[ids_pkg::DEV_UART1] = baseValid(st.devBase[ids_pkg::DEV_UART1], ids_pkg::BASE_MIN,
                                                ids_pkg::ALIGN8_MASK); // see RULE22
  assign baseOk[ids_pkg::DEV_UART2] = baseValid(st.devBase[ids_pkg::DEV_UART2], ids_pkg::BASE_MIN,
                                                ids_pkg::ALIGN8_MASK); // see RULE22
  assign baseOk[ids_pkg::DEV_SCI] = baseValid(st.devBase[ids_pkg::DEV_SCI], 12'h000,
                                              ids_pkg::ALIGN8_MASK); // see RULE22
  assign devOn = st.devActive & baseOk; // see RULE13 see RULE22

  assign ppEcp = st.devGate[ids_pkg::DEV_PP][ids_pkg::GATE_PP_MODE +: 2] == ids_pkg::PP_MODE_ECP;
  assign ecrOn = st.devGate[ids_pkg::DEV_PP][ids_pkg::GATE_PP_ECR_MODE +: 3] == ids_pkg::ECR_FIFO
                 || st.devGate[ids_pkg::DEV_PP][ids_pkg::GATE_PP_ECR_MODE +: 3] == ids_pkg::ECR_ECP
                 || st.devGate[ids_pkg::DEV_PP][ids_pkg::GATE_PP_ECR_MODE +: 3] == ids_pkg::ECR_TEST;

  assign irqEn[ids_pkg::DEV_FDC] = st.devGate[ids_pkg::DEV_FDC][ids_pkg::GATE_FDC_DMA]
                                   && !st.devGate[ids_pkg::DEV_FDC][ids_pkg::GATE_FDC_POWER_DOWN]; // see RULE5
  assign floppy_dma_gate[ids_pkg::DEV_FDC] = irqEn[ids_pkg::DEV_FDC]; // see RULE5 see RULE11
  // Gate clear tri-states SPP/EPP; ECP modes 010/011/110 bypass the gate
  assign irqEn[ids_pkg::DEV_PP] = ppEcp ?
    ((ecrOn || st.devGate[ids_pkg::DEV_PP][ids_pkg::GATE_PP_IRQ])
     && !st.devGate[ids_pkg::DEV_PP][ids_pkg::GATE_PP_SERVICE_MASK]) // see RULE6 see RULE15
    : st.devGate[ids_pkg::DEV_PP][ids_pkg::GATE_PP_IRQ]; // see RULE14
  assign floppy_dma_gate[ids_pkg::DEV_PP] = ppEcp && st.devGate[ids_pkg::DEV_PP][ids_pkg::GATE_PP_ECP_DMA]; // see RULE15
  assign irqEn[ids_pkg::DEV_UART1] = |st.devGate[ids_pkg::DEV_UART1][ids_pkg::GATE_UART_IER +: 4]
                                     && st.devGate[ids_pkg::DEV_UART1][ids_pkg::GATE_UART_AUX]; // see RULE7 see RULE8
  assign irqEn[ids_pkg::DEV_UART2] = |st.devGate[ids_pkg::DEV_UART2][ids_pkg::GATE_UART_IER +: 4]
                                     && st.devGate[ids_pkg::DEV_UART2][ids_pkg::GATE_UART_AUX]; // see RULE7 see RULE8
  assign floppy_dma_gate[ids_pkg::DEV_UART1] = 1'b0;
  assign floppy_dma_gate[ids_pkg::DEV_UART2] = 1'b0;
  assign irqEn[ids_pkg::DEV_SCI] = 1'b1;
  assign floppy_dma_gate[ids_pkg::DEV_SCI] = 1'b0;
  assign activeLow = {3'b000, st.devGate[ids_pkg::DEV_PP][ids_pkg::GATE_PP_MODE +: 2] != ids_pkg::PP_MODE_SPP,
                      1'b0}; // see RULE3

  // ==========================================================
  // Per-device routing
  genvar gi;
  generate
    for (gi = 0; gi < ids_pkg::NUM_DEV; gi++) begin : gRoute
      ids_route #(.IS_SCI(gi == ids_pkg::DEV_SCI)) uRoute (
        .irqSel(st.irqSel[gi]),
        .dmaSel(st.dmaSel[gi]),
        .devOn(devOn[gi]),
        .irqEnable(irqEn[gi]),
        .dmaEnable(floppy_dma_gate[gi]),
        .irqActiveLow(activeLow[gi]),
        .irqReq(devIrqReq[gi]),
        .dma_request_line(devDmaReq[gi]),
        .irqDrive(routeIrqDrive[gi]),
        .irqValue(routeIrqValue[gi]),
        .dmaDrive(routeDmaDrive[gi]),
        .dmaValue(routeDmaValue[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Register read decode
  assign bank = st.pready ? 3'h7 : apbReq.paddr[10:8];
  assign regOff = apbReq.paddr[7:0];
  assign pmOff = st.addrSync[3:0];

  always_comb begin
    rdWord = {1'b0, 32'h0000_0000};
    if (!apbReq.paddr[11] && bank < ids_pkg::NUM_DEV) begin
      unique case (regOff)
        ids_pkg::OFF_ACTIVATE: rdWord = {1'b1, 31'h0000_0000, st.devActive[bank]};
        ids_pkg::OFF_BASE: rdWord = {1'b1, 20'h00000, st.devBase[bank]};
        ids_pkg::OFF_IRQ_SEL: rdWord = {1'b1, 28'h000_0000, st.irqSel[bank]}; // see RULE23
        ids_pkg::OFF_DMA_SEL: rdWord = {1'b1, 29'h000_0000, st.dmaSel[bank]}; // see RULE23
        ids_pkg::OFF_GATE: rdWord = {1'b1, 16'h0000, st.devGate[bank]};
        default: rdWord = {1'b0, 32'h0000_0000};
      endcase
    end else if (!apbReq.paddr[11] && bank == ids_pkg::BANK_GLOBAL) begin
      unique case (regOff)
        ids_pkg::OFF_TASK_BASE: rdWord = {1'b1, 20'h00000, st.taskBase};
        ids_pkg::OFF_MISC_BASE: rdWord = {1'b1, 20'h00000, st.miscBase};
        ids_pkg::OFF_TWO_WIRE_BASE: rdWord = {1'b1, 20'h00000, st.twoWireBase};
        ids_pkg::OFF_PM_BASE: rdWord = {1'b1, 20'h00000, st.pmBase};
        ids_pkg::OFF_LINE_STATUS: rdWord = {1'b1, 12'h000, st.dmaLine, st.irqLine};
        default: rdWord = {1'b0, 32'h0000_0000};
      endcase
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    anyIrqDrive = 16'h0000;
    anyIrqValue = 16'h0000;
    anyDmaDrive = 4'h0;
    anyDmaValue = 4'h0;
    for (int d = 0; d < ids_pkg::NUM_DEV; d++) begin
      anyIrqDrive = anyIrqDrive | routeIrqDrive[d];
      anyIrqValue = anyIrqValue | routeIrqValue[d];
      anyDmaDrive = anyDmaDrive | routeDmaDrive[d];
      anyDmaValue = anyDmaValue | routeDmaValue[d];
      // Acknowledge reaches a device only through its own live channel
      next_st.devDack[d] = |(routeDmaDrive[d] & ~st.dackSync_n); // see RULE5 see RULE13
    end
    next_st.irqLine = anyIrqValue;
    next_st.irqOe_n = ~anyIrqDrive; // see RULE9
    next_st.dmaLine = anyDmaValue;
    next_st.dmaOe_n = ~anyDmaDrive; // see RULE12

    // Pins from the ISA side pass two flops before decode
    next_st.addrMeta = isaAddr; // see RULE17
    next_st.addrSync = st.addrMeta;
    next_st.dackMeta_n = dmaAck_n;
    next_st.dackSync_n = st.dackMeta_n;

    // Decode needs no enable beyond its base registers, except system control decode, which also needs its device on
    next_st.taskSelect_n = st.addrSync[11:3] != st.taskBase[11:3]; // see RULE16 see RULE18
    next_st.auxSelect_n = st.addrSync != st.miscBase; // see RULE18
    next_st.twoWireHit = st.addrSync[11:2] == st.twoWireBase[11:2]; // see RULE19
    next_st.twoWireOffset = st.addrSync[1:0];
    next_st.pmHit = st.addrSync[11:4] == st.pmBase[11:4]
                    && (pmOff <= ids_pkg::PM_LAST_CTRL
                        || (pmOff >= ids_pkg::PM_TIMER_FIRST && pmOff <= ids_pkg::PM_TIMER_LAST)); // see RULE20
    next_st.pmOffset = pmOff;
    next_st.sciHit = devOn[ids_pkg::DEV_SCI] && st.addrSync[11:3] == st.devBase[ids_pkg::DEV_SCI][11:3]
                     && st.addrSync[2:0] != ids_pkg::SCI_RESERVED; // see RULE21 see RULE22
    next_st.sciOffset = st.addrSync[2:0];

    // Zero-wait slave: read data captured in setup, ready in access
    next_st.pready = 1'b0;
    if (apbReq.psel && !apbReq.penable) begin
      next_st.pready = 1'b1;
      next_st.prdata = rdWord[31:0];
      next_st.pslverr = !rdWord[32];
    end
    if (apbReq.psel && apbReq.penable && st.pready && apbReq.pwrite && !st.pslverr) begin
      if (apbReq.paddr[10:8] < ids_pkg::NUM_DEV) begin
        unique case (regOff)
          ids_pkg::OFF_ACTIVATE: next_st.devActive[apbReq.paddr[10:8]] = apbReq.pwdata[0];
          ids_pkg::OFF_BASE: next_st.devBase[apbReq.paddr[10:8]] = apbReq.pwdata[11:0];
          ids_pkg::OFF_IRQ_SEL: next_st.irqSel[apbReq.paddr[10:8]] = apbReq.pwdata[3:0]; // see RULE23
          ids_pkg::OFF_DMA_SEL: next_st.dmaSel[apbReq.paddr[10:8]] = apbReq.pwdata[2:0]; // see RULE23
          ids_pkg::OFF_GATE: next_st.devGate[apbReq.paddr[10:8]] = apbReq.pwdata[15:0];
          default: next_st.pslverr = st.pslverr;
        endcase
      end else begin
        unique case (regOff)
          ids_pkg::OFF_TASK_BASE: next_st.taskBase = apbReq.pwdata[11:0];
          ids_pkg::OFF_MISC_BASE: next_st.miscBase = apbReq.pwdata[11:0];
          ids_pkg::OFF_TWO_WIRE_BASE: next_st.twoWireBase = apbReq.pwdata[11:0];
          ids_pkg::OFF_PM_BASE: next_st.pmBase = apbReq.pwdata[11:0];
          default: next_st.pslverr = st.pslverr;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.irqSel <= {ids_pkg::NUM_DEV{ids_pkg::IRQ_SEL_RESET}};
      st.dmaSel <= {ids_pkg::NUM_DEV{ids_pkg::DMA_SEL_RESET}};
      st.irqOe_n <= 16'hFFFF;
      st.dmaOe_n <= 4'hF;
      st.dackMeta_n <= 4'hF;
      st.dackSync_n <= 4'hF;
      st.taskSelect_n <= 1'b1;
      st.auxSelect_n <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign devDack = st.devDack;
  assign irqLine = st.irqLine;
  assign irqOe_n = st.irqOe_n;
  assign dmaLine = st.dmaLine;
  assign dmaOe_n = st.dmaOe_n;
  assign driveTaskSelect_n = st.taskSelect_n;
  assign driveAuxSelect_n = st.auxSelect_n;
  assign twoWireHit = st.twoWireHit;
  assign twoWireOffset = st.twoWireOffset;
  assign pmHit = st.pmHit;
  assign pmOffset = st.pmOffset;
  assign sciHit = st.sciHit;
  assign sciOffset = st.sciOffset;

  // ==========================================================
  // Checks; sampled only on enabled edges since state is frozen otherwise
  default clocking cb @(posedge core_clk iff ce); endclocking
  default disable iff (sys_rst);

  a_irq_code_map: assert property ( // see RULE1
    (devOn[2] && irqEn[2] && st.irqSel[2] == 4'h3) |=> !st.irqOe_n[3])
    else $error("selected code 3 did not enable line 3");
  a_irq13_reserved: assert property ( // see RULE2
    (st.irqSel[0] == 4'hD) |-> routeIrqDrive[0] == 16'h0000)
    else $error("non-control device drove line 13");
  a_irq_hiz_unused: assert property ( // see RULE9
    1'b1 |=> st.irqOe_n == ~$past(anyIrqDrive))
    else $error("interrupt enable does not match selection");
  a_fdc_gate_off: assert property ( // see RULE5
    (!irqEn[0]) |-> (routeIrqDrive[0] == 16'h0000 && routeDmaDrive[0] == 4'h0))
    else $error("floppy lines driven while gated");
  a_uart_aux_off: assert property ( // see RULE8
    (!st.devGate[2][10]) |-> routeIrqDrive[2] == 16'h0000)
    else $error("serial interrupt driven with aux low");
  a_dma_none_code: assert property ( // see RULE10
    (st.dmaSel[0][2]) |=> !st.devDack[0])
    else $error("acknowledge on inactive channel code");
  a_dma_hiz_unused: assert property ( // see RULE12
    1'b1 |=> st.dmaOe_n == ~$past(anyDmaDrive))
    else $error("request enable does not match selection");
  a_bad_base_off: assert property ( // see RULE22
    (!baseOk[0]) |-> routeIrqDrive[0] == 16'h0000)
    else $error("device with invalid base drove a line");
  a_task_select: assert property ( // see RULE18
    (st.addrSync[11:3] == st.taskBase[11:3] && !sys_rst) |=> !st.taskSelect_n)
    else $error("task select missed its window");
  a_ecp_irq_on: assert property ( // see RULE15
    (ppEcp && ecrOn && !st.devGate[1][2]) |-> irqEn[1])
    else $error("enhanced mode interrupt not forced on");
  a_pp_gate_off: assert property ( // see RULE14
    (!ppEcp && !st.devGate[1][4]) |-> routeIrqDrive[1] == '0)
    else $error("parallel irq driven with gate clear");
  a_ecp_mask_off: assert property ( // see RULE6
    (ppEcp && st.devGate[1][2]) |-> routeIrqDrive[1] == '0)
    else $error("parallel irq driven while masked");
  a_ecp_dma_gate: assert property ( // see RULE15
    (ppEcp && !st.devGate[1][3]) |-> routeDmaDrive[1] == '0)
    else $error("parallel request driven with gate clear");
  a_uart_no_enable: assert property ( // see RULE7
    (st.devGate[2][3:0] == 4'h0) |-> routeIrqDrive[2] == '0)
    else $error("serial irq driven with no enable");
  a_dma_code_map: assert property ( // see RULE11
    (devOn[0] && floppy_dma_gate[0] && st.dmaSel[0] == 3'h1) |=> !st.dmaOe_n[1])
    else $error("channel 1 not driven");
  a_aux_select: assert property ( // see RULE18
    (st.addrSync == st.miscBase && !sys_rst) |=> !st.auxSelect_n)
    else $error("aux select missed its address");
  a_sci_reserved: assert property ( // see RULE21
    st.sciHit |-> st.sciOffset != 3'h5)
    else $error("reserved offset decoded");

  // Scenario covers
  c_irq_driven: cover property (!st.irqOe_n[3] ##1 st.irqLine[3]);
  c_ecp_irq: cover property (ppEcp && ecrOn && irqEn[1]);
  c_dma_ack: cover property (st.devDack[0]);
  c_apb_write: cover property (apbReq.psel && apbReq.penable && st.pready && apbReq.pwrite);
  c_two_wire_hit: cover property (st.twoWireHit);

endmodule

// ===== ids_host_model.sv
module ids_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Request lines from the block
  input wire logic [3:0] dmaLine,
  input wire logic [3:0] dmaOe_n,
  input wire logic slowAck,
  // Acknowledge back to the block
  output logic [3:0] dmaAck_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int waitCnt [4];
  // ==========================================================
  // Acknowledge a driven request, promptly or slowly
  // A released acknowledge line has a pull-up, so it returns high
  always @(posedge core_clk or posedge sys_rst) begin
    for (int c = 0; c < 4; c++) begin
      if (sys_rst || dmaOe_n[c] !== 1'b0 || dmaLine[c] !== 1'b1) begin
        waitCnt[c] <= 0;
        dmaAck_n[c] <= 1'b1;
      end else if (waitCnt[c] < (slowAck ? 6 : 1)) begin
        waitCnt[c] <= waitCnt[c] + 1;
      end else begin
        dmaAck_n[c] <= 1'b0;
      end
    end
  end
endmodule

// ===== ids_steering_test.sv
module ids_steering_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic slowAck = 1'b0;
  ids_pkg::ids_apb_req_type apbReq = '0;
  logic [4:0] devIrqReq = '0;
  logic [4:0] devDmaReq = '0;
  logic [11:0] isaAddr = '0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, taskSel_n, auxSel_n, twHit, pmHit, sciHit;
  logic [4:0] devDack;
  logic [3:0] dmaAck_n, dmaLine, dmaOe_n, pmOff;
  logic [15:0] irqLine, irqOe_n;
  logic [1:0] twOff;
  logic [2:0] sciOff;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [8:0] ppGate [6] = '{9'h000, 9'h010, 9'h012, 9'h016, 9'h042, 9'h00A};
  logic [2:0] ppExp [6] = '{3'h5, 3'h3, 3'h1, 3'h5, 3'h1, 3'h4};

  always #2 core_clk = ~core_clk;

  ids_steering i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .devIrqReq(devIrqReq), .devDmaReq(devDmaReq), .devDack(devDack),
    .isaAddr(isaAddr), .dmaAck_n(dmaAck_n), .irqLine(irqLine), .irqOe_n(irqOe_n), .dmaLine(dmaLine),
    .dmaOe_n(dmaOe_n), .driveTaskSelect_n(taskSel_n), .driveAuxSelect_n(auxSel_n), .twoWireHit(twHit),
    .twoWireOffset(twOff), .pmHit(pmHit), .pmOffset(pmOff), .sciHit(sciHit), .sciOffset(sciOff));
  ids_host_model i_host (.core_clk(core_clk), .sys_rst(sys_rst), .dmaLine(dmaLine), .dmaOe_n(dmaOe_n),
    .slowAck(slowAck), .dmaAck_n(dmaAck_n));

  // ==========================================================
  // Verdict, comparison and bus tasks
  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; the idle edge at the end keeps drivers single per step
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    apbReq.psel <= 1'b1;
    apbReq.pwrite <= wr;
    apbReq.paddr <= addr;
    apbReq.pwdata <= data;
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic settle();
    repeat (5) @(posedge core_clk);
  endtask

  // Expected output enables: codes 0, 2 and foreign 13 leave every line released
  function automatic logic [15:0] expOe(int code, int dev, bit on);
    logic [15:0] oe;
    oe = 16'hFFFF;
    if (on && code != 0 && code != 2 && (code != 13 || dev == 4)) oe[code] = 1'b0;
    return oe;
  endfunction

  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    int off;
    logic [15:0] e;
    void'($urandom(25));
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, 12'h070, '0);
    chk(rdata, 32'h0);
    apb(1'b0, 12'h074, '0);
    chk(rdata, 32'h4);
    apb(1'b0, 12'h600, '0);
    chk({rdata[30:0], rerr}, 32'h1);
    apb(1'b1, 12'h070, 32'hFF);
    apb(1'b0, 12'h070, '0);
    chk(rdata, 32'hF);
    apb(1'b1, 12'h074, 32'hFF);
    apb(1'b0, 12'h074, '0);
    chk(rdata, 32'h7);
    // Serial port: every level code, then each disabling gate
    apb(1'b1, 12'h260, 32'h3F8);
    apb(1'b1, 12'h230, 32'h1);
    apb(1'b1, 12'h280, 32'h401);
    devIrqReq <= 5'h04;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 12'h270, 32'(c));
      settle();
      e = expOe(c, 2, 1'b1);
      chk({irqOe_n, irqLine & ~irqOe_n}, {e, ~e});
    end
    apb(1'b1, 12'h270, 32'h5);
    apb(1'b1, 12'h280, 32'h001);
    settle();
    chk(32'(irqOe_n), 32'hFFFF);
    apb(1'b1, 12'h280, 32'h400);
    settle();
    chk(32'(irqOe_n), 32'hFFFF);
    apb(1'b1, 12'h280, 32'h401);
    apb(1'b1, 12'h260, 32'h0F8);
    settle();
    chk(32'(irqOe_n), 32'hFFFF);
    // System control device may take line thirteen
    apb(1'b1, 12'h460, 32'h0C8);
    apb(1'b1, 12'h430, 32'h1);
    apb(1'b1, 12'h470, 32'hD);
    devIrqReq <= 5'h10;
    settle();
    chk(32'(irqOe_n), 32'(expOe(13, 4, 1'b1)));
    // Floppy DMA: every channel code, host answering fast or slow
    apb(1'b1, 12'h060, 32'h3F0);
    apb(1'b1, 12'h030, 32'h1);
    apb(1'b1, 12'h080, 32'h8);
    devDmaReq <= 5'h01;
    for (int ch = 0; ch < 8; ch++) begin
      slowAck <= 1'($urandom_range(0, 1));
      apb(1'b1, 12'h074, 32'(ch));
      settle();
      e = (ch < 4) ? ~(16'h1 << ch) : 16'hFFFF;
      chk({dmaOe_n, dmaLine & ~dmaOe_n}, {e[3:0], ~e[3:0]});
      off = 0;
      while (ch < 4 && devDack[0] !== 1'b1 && off < 20) begin
        @(posedge core_clk);
        off++;
      end
      chk(32'(devDack), (ch < 4) ? 32'h1 : 32'h0);
    end
    apb(1'b1, 12'h074, 32'h2);
    apb(1'b1, 12'h080, 32'h9);
    settle();
    chk({dmaOe_n, 3'h0, devDack}, {4'hF, 8'h00});
    apb(1'b1, 12'h080, 32'h0);
    settle();
    chk({dmaOe_n, 3'h0, devDack}, {4'hF, 8'h00});
    // Parallel port: gate, mask, enhanced modes and DMA gate
    apb(1'b1, 12'h160, 32'h378);
    apb(1'b1, 12'h130, 32'h1);
    apb(1'b1, 12'h170, 32'h7);
    apb(1'b1, 12'h174, 32'h1);
    devIrqReq <= 5'h02;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'h180, 32'(ppGate[i]));
      settle();
      chk({irqOe_n[7], irqLine[7] & ~irqOe_n[7], dmaOe_n[1]}, ppExp[i]);
    end
    // Address decode with random offsets
    apb(1'b1, 12'h500, 32'h1F0);
    apb(1'b1, 12'h504, 32'h1F6);
    apb(1'b1, 12'h508, 32'h0A0);
    apb(1'b1, 12'h50C, 32'h800);
    for (int i = 0; i < 12; i++) begin
      off = $urandom_range(0, 15);
      isaAddr <= 12'h1F0 + 12'(off);
      settle();
      chk({taskSel_n, auxSel_n}, {(off >= 8), (off != 6)});
      isaAddr <= 12'h0A0 + 12'(off);
      settle();
      chk({twHit, twOff}, {(off < 4), 2'(off)});
      isaAddr <= 12'h800 + 12'(off);
      settle();
      chk({pmHit, pmOff}, {(off <= 5 || (off >= 8 && off <= 11)), 4'(off)});
      isaAddr <= 12'h0C8 + 12'(off);
      settle();
      chk({sciHit, sciOff}, {(off < 8 && off != 5), 3'(off)});
    end
    // Clock enable low freezes the decode
    ce <= 1'b0;
    isaAddr <= 12'h1F0;
    settle();
    chk(32'(taskSel_n), 32'h1);
    ce <= 1'b1;
    finish_test();
  end
endmodule
